// >>> adc_scan_sequencer_bus_request_bench.sv
`timescale 1ns/100ps
module adc_scan_sequencer_bus_request_bench;
  import adsq_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  adsq_bus_s bus = '0;
  logic scan_trigger = 1'b0;
  logic conv_done = 1'b0;
  logic [7:0] want = 8'h00;
  logic [3:0] lag = 4'h3;
  logic [31:0] rdata;
  logic conv_start;
  logic scan_busy;
  logic [4:0] scan_slot_id;
  adsq_chan_s pos_sel;
  adsq_chan_s neg_sel;
  logic neg_to_ground;
  logic [7:0] other_bus_req;
  logic [7:0] bus_req;
  logic [7:0] bus_passive;
  logic [7:0] bus_grant;
  logic irq;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] d;
  logic [4:0] e_slot[$];
  logic [7:0] e_pos[$];
  logic [7:0] e_neg[$];

  always #25 mclk = ~mclk;

  adsq_sequencer i_adsq_sequencer (.mclk(mclk), .srst(srst), .bus(bus), .rdata(rdata),
    .scan_trigger(scan_trigger), .conv_done(conv_done), .conv_start(conv_start),
    .scan_busy(scan_busy), .scan_slot_id(scan_slot_id), .pos_sel(pos_sel),
    .neg_sel(neg_sel), .neg_to_ground(neg_to_ground), .other_bus_req(other_bus_req),
    .bus_req(bus_req), .bus_passive(bus_passive), .bus_grant(bus_grant), .irq(irq));

  adsq_peer_model i_adsq_peer_model (.mclk(mclk), .srst(srst), .want(want), .lag(lag),
    .other_bus_req(other_bus_req));

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
    chk(name, d, exp);
  endtask

  task automatic trigger();
    @(posedge mclk);
    scan_trigger <= 1'b1;
    @(posedge mclk);
    scan_trigger <= 1'b0;
  endtask

  // Walk the expected slots, answering each conversion at once
  task automatic scan(input logic differential_select);
    trigger();
    foreach (e_slot[i]) begin
      for (int k = 0; k < 10 && conv_start !== 1'b1; k++) begin
        @(posedge mclk);
        #1;
      end
      chk("conv_start", conv_start, 1);
      chk("scan_slot_id", scan_slot_id, e_slot[i]);
      chk("pos_sel", pos_sel, e_pos[i]);
      chk("neg_to_ground", neg_to_ground, !differential_select);
      if (differential_select) begin
        chk("neg_sel", neg_sel, e_neg[i]);
      end
      @(posedge mclk);
      conv_done <= 1'b1;
      @(posedge mclk);
      conv_done <= 1'b0;
    end
    @(posedge mclk);
    #1 chk("scan_busy", scan_busy, 0);
  endtask

  task automatic t_reset();
    chk("irq", irq, 0);
    chk("neg_to_ground", neg_to_ground, 1);
    rd_chk(OFF_GROUPS, GROUPS_RST, "groups");
    rd_chk(OFF_ENABLE, ENABLE_RST, "enable");
    rd_chk(8'h3C, 32'h0000_0000, "unmapped");
  endtask

  task automatic t_single();
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_GROUPS, 32'h3040_8830);
    wr(OFF_ENABLE, 32'h8000_2009);
    e_slot = '{5'd0, 5'd3, 5'd13, 5'd31};
    e_pos = '{8'h30, 8'h33, 8'h8D, 8'h37};
    scan(1'b0);
  endtask

  task automatic t_bus();
    wr(OFF_IEN, 32'h0000_0001);
    rd_chk(OFF_REQ, 32'h0000_0083, "req view");
    wr(OFF_REQ, 32'h0000_00FF);
    rd_chk(OFF_REQ, 32'h0000_0083, "req read only");
    @(posedge mclk);
    want <= 8'h01;
    repeat (8) @(posedge mclk);
    #1 chk("bus_grant", bus_grant, 8'h82);
    chk("irq", irq, 1);
    rd_chk(OFF_CLASH, 32'h0000_0001, "clash view");
    rd_chk(OFF_STATUS, {24'h0, 5'd31, PERR_BUS, 1'b0}, "status");
    want <= 8'h00;
    repeat (6) @(posedge mclk);
    wr(OFF_CLASH, 32'h0000_00FF);
    wr(OFF_IFLAG, 32'h0000_0001);
    rd_chk(OFF_CLASH, 32'h0000_0000, "clash cleared");
    chk("irq", irq, 0);
    wr(OFF_MDIS, 32'hFFFF_FFFF);
    want <= 8'h01;
    repeat (8) @(posedge mclk);
    #1 chk("bus_req", bus_req, 8'h00);
    chk("bus_passive", bus_passive, 8'h83);
    rd_chk(OFF_CLASH, 32'h0000_0000, "passive clash");
    want <= 8'h00;
    repeat (6) @(posedge mclk);
    wr(OFF_MDIS, 32'h0000_0000);
  endtask

  task automatic t_differential_select();
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_GROUPS, 32'h3058_8830);
    wr(OFF_REMAP, 32'h0003_0812);
    wr(OFF_ENABLE, 32'h0080_8214);
    e_slot = '{5'd2, 5'd4, 5'd9, 5'd15, 5'd23};
    e_pos = '{8'h32, 8'h34, 8'h89, 8'h8F, 8'h5F};
    e_neg = '{8'h35, 8'h35, 8'h8E, 8'h88, 8'h40};
    scan(1'b1);
    wr(OFF_REMAP, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0000);
  endtask

  // Port 0 is private to the converter, so a busy peer cannot clash with it
  task automatic t_port0_empty();
    logic seen;
    seen = 1'b0;
    wr(OFF_GROUPS, 32'h0000_0000);
    wr(OFF_ENABLE, 32'h0000_0001);
    want <= 8'hFF;
    repeat (8) @(posedge mclk);
    rd_chk(OFF_REQ, 32'h0000_0000, "port0 req");
    rd_chk(OFF_CLASH, 32'h0000_0000, "port0 clash");
    want <= 8'h00;
    wr(OFF_ENABLE, 32'h0000_0000);
    trigger();
    repeat (6) begin
      @(posedge mclk);
      #1 seen = seen | conv_start | scan_busy;
    end
    chk("empty scan", seen, 0);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_single();
    t_bus();
    t_differential_select();
    t_port0_empty();
    finish_test();
  end
endmodule

// >>> adsq_peer_model.sv
`timescale 1ns/100ps
module adsq_peer_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Bench control: wanted buses and response lag
  input wire logic [7:0] want,
  input wire logic [3:0] lag,
  // Requests seen by the converter
  output logic [7:0] other_bus_req
);
  logic [3:0] wait_cnt;

  // A slow peer settles on a new request set lag+1 cycles after the wanted set changes
  always_ff @(posedge mclk) begin
    if (srst) begin
      other_bus_req <= 8'h00;
      wait_cnt <= 4'h0;
    end else if (want == other_bus_req) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= lag) begin
      other_bus_req <= want;
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// >>> adsq_pkg.sv
// Functional notes
// - One trigger converts up to 32 scan slots in sequence, no firmware help.
// - Scan inputs are analog-port channels only; no internal nodes selectable.
// - Scanner itself loads positive and negative mux selections for each next slot.
// - 32 slots in four groups of 8; slot k maps to block base plus k.
// - Each group picks any port block independently; repeats allowed.
// - Slot enable register has one bit per slot, bit number equals slot.
// - Scan starts at slot 0, converts enabled slots only, ascending order.
// - Single-ended: channel on one input, other input grounded; X or Y bus.
// - Differential default: negative is next higher channel on the same port.
// - Differential slot 15 takes slot 8's channel as negative input.
// - Differential positive channel 31 takes channel 0 of same port as negative.
// - Remap lets slots 0,2,4,6 take odd slot 1,3,5,7 as negative.
// - Remap lets slots 9,11,13,15 take even slot 8,10,12,14 as negative.
// - Same shared bus requested by both parties: granted to neither, conflict flagged.
// - Request view register shows shared buses requested by current selections.
// - Conflict view records every bus clash; with error enable, raises interrupt.
// - Status error field tells bus clash from negative-input clash.
// - Clearing a persisting negative-input clash drops flag one cycle, then resets.
// - Bus requested once selected, even idle; released only when selection changes.
// - Bus master disable: passive connection, no switch control, never a clash.
// - Only ports 1 to 4 are shared; port 0 never clashes.
// - Shared ports: even channels on X bus, odd channels on Y bus.
// - Differential pair both X or both Y flags a negative-input clash.
package adsq_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GROUPS = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_REMAP = 8'h0C;
  localparam logic [7:0] OFF_REQ = 8'h10;
  localparam logic [7:0] OFF_CLASH = 8'h14;
  localparam logic [7:0] OFF_MDIS = 8'h18;
  localparam logic [7:0] OFF_IEN = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IFLAG = 8'h24;
  localparam int CTRL_DIFFERENTIAL_SELECT_BIT = 0;
  localparam int IEN_PERR_BIT = 0;
  localparam int GRP_PORT_LSB = 5;
  localparam int GRP_BLK_LSB = 3;
  localparam int REMAP_SEL_LSB = 8;
  localparam logic [31:0] GROUPS_RST = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [2:0] PORT_LAST = 3'h4;
  localparam logic [1:0] PERR_NONE = 2'h0;
  localparam logic [1:0] PERR_BUS = 2'h1;
  localparam logic [1:0] PERR_NEG = 2'h2;

  typedef struct packed {
    logic [2:0] port;
    logic [4:0] chan;
  } adsq_chan_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } adsq_bus_s;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'h0,
    SQ_LOAD = 2'h1,
    SQ_WAIT = 2'h3
  } adsq_state_e;

  // Slot to physical channel through its group's block selection
  function automatic adsq_chan_s slot_chan(logic [31:0] grp, logic [4:0] s);
    logic [7:0] fld;
    adsq_chan_s c;
    fld = grp[{s[4:3], 3'h0} +: 8];
    c.port = fld[GRP_PORT_LSB +: 3];
    c.chan = {fld[GRP_BLK_LSB +: 2], s[2:0]};
    return c;
  endfunction

  // One-hot shared bus: index {port-1, Y}
  function automatic logic [7:0] bus_bit(adsq_chan_s c);
    logic [2:0] idx;
    idx = 3'({c.port - 3'h1, 1'b0}) | {2'h0, c.chan[0]};
    if (c.port >= 3'h1 && c.port <= PORT_LAST) begin
      return 8'h01 << idx;
    end
    return 8'h00;
  endfunction
endpackage

// >>> adsq_sequencer.sv
`timescale 1ns/100ps
module adsq_sequencer
  import adsq_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire adsq_bus_s bus,
  output logic [31:0] rdata,
  // Converter handshake
  input wire logic scan_trigger,
  input wire logic conv_done,
  output logic conv_start,
  output logic scan_busy,
  output logic [4:0] scan_slot_id,
  // Input multiplexer selections
  output adsq_chan_s pos_sel,
  output adsq_chan_s neg_sel,
  output logic neg_to_ground,
  // Shared analog buses
  input wire logic [7:0] other_bus_req,
  output logic [7:0] bus_req,
  output logic [7:0] bus_passive,
  output logic [7:0] bus_grant,
  // Interrupt
  output logic irq
);
  logic ctrl_differential_select;
  logic [31:0] scan_group_select;
  logic [31:0] scan_slot_enable_bits;
  logic [23:0] scan_negative_remap;
  logic [7:0] bus_master_disable;
  logic irq_enable_reg;
  logic [7:0] bus_conflict_view;
  logic perr_flag;
  logic [1:0] perr_type;
  adsq_state_e state;
  logic [4:0] cur;
  logic [7:0] next_req;
  logic neg_cond;
  logic [7:0] clash;
  logic [5:0] first_hit;
  logic [5:0] next_hit;
  logic wr_hit_if;

  // Lowest enabled slot at or above the start point; bit 5 flags a hit
  function automatic logic [5:0] find_slot(logic [31:0] m, logic [5:0] from);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (m[i] && 6'(i) >= from) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // Negative input of a differential slot
  function automatic adsq_chan_s neg_of(logic [31:0] grp, logic [23:0] rm,
                                        logic [4:0] s);
    adsq_chan_s p;
    adsq_chan_s n;
    logic [2:0] i;
    p = slot_chan(grp, s);
    n = p;
    n.chan = p.chan + 5'h01;
    if (p.chan == 5'h1F) begin
      n.chan = 5'h00;
    end
    if (s == 5'd15) begin
      n = slot_chan(grp, 5'd8);
    end
    i = {s[3], s[2:1]};
    if (s[4] == 1'b0 && s[3] == s[0] && rm[i]) begin
      if (s[3] == 1'b0) begin
        n = slot_chan(grp, {2'h0, rm[REMAP_SEL_LSB + 2*i +: 2], 1'b1});
      end else begin
        n = slot_chan(grp, {2'h1, rm[REMAP_SEL_LSB + 2*i +: 2], 1'b0});
      end
    end
    return n;
  endfunction

  assign wr_hit_if = bus.wr && bus.addr == OFF_IFLAG && bus.wdata[0];

  // Requests follow the selection registers, not the scan activity
  always_comb begin
    adsq_chan_s p;
    adsq_chan_s n;
    p = '0;
    n = '0;
    next_req = 8'h00;
    neg_cond = 1'b0;
    for (int s = 0; s < 32; s++) begin
      p = slot_chan(scan_group_select, 5'(s));
      n = neg_of(scan_group_select, scan_negative_remap, 5'(s));
      if (scan_slot_enable_bits[s]) begin
        next_req = next_req | bus_bit(p);
        if (ctrl_differential_select) begin
          next_req = next_req | bus_bit(n);
          if (p.chan[0] == n.chan[0]) begin
            neg_cond = 1'b1;
          end
        end
      end
    end
  end

  // Shared buses: requested view and passive monitoring
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_req <= 8'h00;
      bus_passive <= 8'h00;
    end else begin
      bus_req <= next_req & ~bus_master_disable;
      bus_passive <= next_req & bus_master_disable;
    end
  end

  assign clash = bus_req & other_bus_req;
  assign bus_grant = bus_req & ~other_bus_req;

  // Software registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_differential_select <= 1'b0;
      scan_group_select <= GROUPS_RST;
      scan_slot_enable_bits <= ENABLE_RST;
      scan_negative_remap <= 24'h000000;
      bus_master_disable <= 8'h00;
      irq_enable_reg <= 1'b0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        OFF_CTRL: ctrl_differential_select <= bus.wdata[CTRL_DIFFERENTIAL_SELECT_BIT];
        OFF_GROUPS: scan_group_select <= bus.wdata;
        OFF_ENABLE: scan_slot_enable_bits <= bus.wdata;
        OFF_REMAP: scan_negative_remap <= bus.wdata[23:0];
        OFF_MDIS: bus_master_disable <= bus.wdata[7:0];
        OFF_IEN: irq_enable_reg <= bus.wdata[IEN_PERR_BIT];
        default: ;
      endcase
    end
  end

  // Sticky clash record; a new clash beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_conflict_view <= 8'h00;
    end else if (bus.wr && bus.addr == OFF_CLASH) begin
      bus_conflict_view <= (bus_conflict_view & ~bus.wdata[7:0]) | clash;
    end else begin
      bus_conflict_view <= bus_conflict_view | clash;
    end
  end

  // Error flag: a persisting negative clash is dropped by a clear for one
  // cycle only, since the level is sampled again on the next edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      perr_flag <= 1'b0;
      perr_type <= PERR_NONE;
    end else if (|clash) begin
      perr_flag <= 1'b1;
      perr_type <= PERR_BUS;
    end else if (wr_hit_if) begin
      perr_flag <= 1'b0;
    end else if (neg_cond) begin
      perr_flag <= 1'b1;
      perr_type <= PERR_NEG;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= perr_flag && irq_enable_reg;
    end
  end

  // Read port
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        OFF_CTRL: rdata <= {31'h0, ctrl_differential_select};
        OFF_GROUPS: rdata <= scan_group_select;
        OFF_ENABLE: rdata <= scan_slot_enable_bits;
        OFF_REMAP: rdata <= {8'h00, scan_negative_remap};
        OFF_REQ: rdata <= {24'h0, bus_req};
        OFF_CLASH: rdata <= {24'h0, bus_conflict_view};
        OFF_MDIS: rdata <= {24'h0, bus_master_disable};
        OFF_IEN: rdata <= {31'h0, irq_enable_reg};
        OFF_STATUS: rdata <= {24'h0, scan_slot_id, perr_type, scan_busy};
        OFF_IFLAG: rdata <= {31'h0, perr_flag};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  assign first_hit = find_slot(scan_slot_enable_bits, 6'h00);
  assign next_hit = find_slot(scan_slot_enable_bits, 6'({1'b0, cur}) + 6'h01);

  // Scan walk
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= SQ_IDLE;
      cur <= 5'h00;
    end else begin
      unique case (state)
        SQ_IDLE: begin
          if (scan_trigger && first_hit[5]) begin
            cur <= first_hit[4:0];
            state <= SQ_LOAD;
          end
        end
        SQ_LOAD: state <= SQ_WAIT;
        SQ_WAIT: begin
          if (conv_done) begin
            if (next_hit[5]) begin
              cur <= next_hit[4:0];
              state <= SQ_LOAD;
            end else begin
              state <= SQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Mux selections loaded by the scanner before each conversion
  always_ff @(posedge mclk) begin
    if (srst) begin
      pos_sel <= '0;
      neg_sel <= '0;
      neg_to_ground <= 1'b1;
      conv_start <= 1'b0;
      scan_slot_id <= 5'h00;
    end else begin
      conv_start <= state == SQ_LOAD;
      if (state == SQ_LOAD) begin
        scan_slot_id <= cur;
        pos_sel <= slot_chan(scan_group_select, cur);
        neg_sel <= neg_of(scan_group_select, scan_negative_remap, cur);
        neg_to_ground <= !ctrl_differential_select;
      end
    end
  end

  assign scan_busy = state != SQ_IDLE;

  logic [4:0] prev_id;
  logic first_conv;
  logic [31:0] mask_seen;
  // Mask as the walk saw it when it picked cur; software may rewrite it live
  always_ff @(posedge mclk) begin
    mask_seen <= scan_slot_enable_bits;
  end

  always_ff @(posedge mclk) begin
    if (srst || state == SQ_IDLE) begin
      first_conv <= 1'b1;
      prev_id <= 5'h00;
    end else if (conv_start) begin
      first_conv <= 1'b0;
      prev_id <= scan_slot_id;
    end
  end

  empty_scan_a: assert property (@(posedge mclk) disable iff (srst)
    state == SQ_IDLE && scan_slot_enable_bits == 32'h0 |=> ##1 !conv_start)
    else $error("conversion started with no slot enabled");
  no_grant_a: assert property (@(posedge mclk) disable iff (srst)
    |clash |-> (bus_grant != bus_req) ##1 (perr_flag && perr_type == PERR_BUS))
    else $error("bus clash granted or not flagged");
  clash_kept_a: assert property (@(posedge mclk) disable iff (srst)
    |clash |=> (bus_conflict_view & $past(clash)) == $past(clash))
    else $error("clash not recorded");
  passive_a: assert property (@(posedge mclk) disable iff (srst)
    ##1 (bus_req & $past(bus_master_disable)) == 8'h00)
    else $error("master disabled bus still requested");
  irq_path_a: assert property (@(posedge mclk) disable iff (srst)
    perr_flag && irq_enable_reg |=> irq)
    else $error("error interrupt missing");
  neg_drop_a: assert property (@(posedge mclk) disable iff (srst)
    wr_hit_if && neg_cond && !(|clash) |=> !perr_flag ##1 (perr_flag || !$past(neg_cond)))
    else $error("negative clash flag not re-raised");
  slot_enabled_a: assert property (@(posedge mclk) disable iff (srst)
    state == SQ_LOAD |-> mask_seen[cur])
    else $error("disabled slot converted");
  ascending_a: assert property (@(posedge mclk) disable iff (srst)
    conv_start && !first_conv |-> scan_slot_id > prev_id)
    else $error("slot order not ascending");
  ground_a: assert property (@(posedge mclk) disable iff (srst)
    conv_start |-> neg_to_ground == !$past(ctrl_differential_select))
    else $error("negative input grounding wrong");
  cross_bus_a: assert property (@(posedge mclk) disable iff (srst)
    conv_start && !neg_to_ground |-> neg_sel.chan[0] != pos_sel.chan[0])
    else $error("differential pair on one sub-bus");
  next_chan_a: assert property (@(posedge mclk) disable iff (srst)
    state == SQ_LOAD && ctrl_differential_select && (cur[4] || (!cur[3] && cur[0])) |=>
    neg_sel.port == pos_sel.port && neg_sel.chan == 5'(pos_sel.chan + 5'h01))
    else $error("default negative input wrong");
endmodule
